// file: common/line_monitor_defines.svh
// Register indices, reset values and field layout for the line voltage and power monitor bank
`ifndef LINE_MONITOR_DEFINES_SVH
`define LINE_MONITOR_DEFINES_SVH

// Printed offsets are register indices; the byte address is four times the index
`define LM_IDX_COMMON_MODE 8'h49
`define LM_IDX_HIGH_BATTERY 8'h4A
`define LM_IDX_LOW_BATTERY 8'h4B
`define LM_IDX_POWER_SELECT 8'h4C
`define LM_IDX_POWER_READING 8'h4D

`define LM_LEVEL_WIDTH 6
`define LM_SELECT_WIDTH 3
`define LM_READING_WIDTH 8
`define LM_DATA_WIDTH 32

// Level codes count 1.5 V steps below ground
`define LM_RESET_COMMON_MODE 6'h02
`define LM_RESET_HIGH_BATTERY 6'h32
`define LM_RESET_LOW_BATTERY 6'h10
`define LM_RESET_POWER_SELECT 3'h0
`define LM_RESET_READING 8'h00

// Pointer codes two and three (transistors three and four) use the fine power scale
`define LM_LOW_RANGE_CODE_A 3'h2
`define LM_LOW_RANGE_CODE_B 3'h3

`define LM_IDLE_DATA 32'h00000000
`define LM_BYTE_LANE_LOW 0

`endif

// file: common/line_monitor_pkg.sv
// Types shared by the line voltage and power monitor bank
`include "line_monitor_defines.svh"

package line_monitor_pkg;

  typedef logic [`LM_LEVEL_WIDTH-1:0] level_code_t;
  typedef logic [`LM_SELECT_WIDTH-1:0] select_code_t;
  typedef logic [`LM_READING_WIDTH-1:0] reading_code_t;

  typedef struct packed {
    level_code_t commonMode;
    level_code_t highBattery;
    level_code_t lowBattery;
  } line_settings_t;

  typedef enum logic [1:0] {
    APB_IDLE = 2'b01,
    APB_ACCESS = 2'b10
  } apb_state_t;

  function automatic logic isLowRangeCode(input select_code_t code);
    isLowRangeCode = (code == `LM_LOW_RANGE_CODE_A) || (code == `LM_LOW_RANGE_CODE_B);
  endfunction

endpackage

// file: hdl/ctrl_field_reg.sv
// Writable control field with a constant reset value
`timescale 1ns/10ps
`default_nettype none

module ctrl_field_reg #(
  parameter int WIDTH = 6,
  parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic writeEnable,
  input wire logic [WIDTH-1:0] writeData,
  output logic [WIDTH-1:0] value
);

  // Refused while the design is elaborated, before any clock runs
  if (WIDTH < 1) begin : gen_width_check
    $error("ctrl_field_reg needs a width of at least one bit");
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      value <= RESET_VALUE;
    end else if (writeEnable) begin
      value <= writeData;
    end
  end

endmodule

`default_nettype wire

// file: hdl/line_voltage_power_monitor_regs.sv
// APB register bank for line voltage targets and transistor power monitoring
//
// Function
// [RULE1] Six-bit common-mode code sets tip or ring level, 0 to -94.5 V, 1.5 V steps.
// [RULE2] Common-mode code resets to the level for -3 V.
// [RULE3] Six-bit high battery code, same range, resets to the -75 V level.
// [RULE4] Six-bit low battery code, same range, resets to the -24 V level.
// [RULE5] Software keeps high battery magnitude at or above low battery magnitude.
// [RULE6] Three-bit pointer picks transistor one to six; codes six and seven undefined.
// [RULE7] Read-only eight-bit reading follows power of the selected transistor live.
// [RULE8] Transistors one, two, five, six: 30.4 mW per count, 7.8 W full scale.
// [RULE9] Transistors three and four: 3.62 mW per count, 0.9 W full scale.
// [RULE10] Unused upper bits of every register read back as zero.
`timescale 1ns/10ps
`default_nettype none
`include "line_monitor_defines.svh"

module line_voltage_power_monitor_regs
  import line_monitor_pkg::*;
#(
  parameter int ADDR_WIDTH = 12,
  parameter int CHANNELS = 6
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_WIDTH-1:0] paddr,
  input wire logic [`LM_DATA_WIDTH-1:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [`LM_DATA_WIDTH-1:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [CHANNELS-1:0][`LM_READING_WIDTH-1:0] transistorPower,
  output line_settings_t lineSettings,
  output select_code_t powerMonitorSelect,
  output logic lowRangeSelected
);

  // Both checks stop elaboration rather than letting a bad build run
  if (ADDR_WIDTH < 10 || ADDR_WIDTH > 32) begin : gen_addr_check
    $error("ADDR_WIDTH must hold the highest register byte address");
  end
  if (CHANNELS != 6) begin : gen_channel_check
    $error("The pointer decode serves exactly six transistors");
  end

  function automatic logic [ADDR_WIDTH-1:0] byteAddr(input logic [7:0] index);
    byteAddr = ADDR_WIDTH'({index, 2'b00});
  endfunction

  apb_state_t apbState_reg;
  apb_state_t apbState_next;
  logic [`LM_DATA_WIDTH-1:0] prdata_next;
  reading_code_t powerReading;

  wire setupPhase = psel && !penable && (apbState_reg == APB_IDLE);
  wire accessDone = psel && penable && (apbState_reg == APB_ACCESS);

  wire hitCommonMode = paddr == byteAddr(`LM_IDX_COMMON_MODE);
  wire hitHighBattery = paddr == byteAddr(`LM_IDX_HIGH_BATTERY);
  wire hitLowBattery = paddr == byteAddr(`LM_IDX_LOW_BATTERY);
  wire hitPowerSelect = paddr == byteAddr(`LM_IDX_POWER_SELECT);
  wire hitPowerReading = paddr == byteAddr(`LM_IDX_POWER_READING);
  wire hitAny = hitCommonMode | hitHighBattery | hitLowBattery | hitPowerSelect | hitPowerReading;

  // Reading register is read-only, so a write there is flagged rather than dropped silently
  wire accessBad = !hitAny || (pwrite && hitPowerReading);

  // Only the low byte lane carries a field; a write without it stores nothing
  wire writeCommit = accessDone && pwrite && !accessBad && pstrb[`LM_BYTE_LANE_LOW];
  wire writeCommonMode = writeCommit && hitCommonMode;
  wire writeHighBattery = writeCommit && hitHighBattery;
  wire writeLowBattery = writeCommit && hitLowBattery;
  wire writePowerSelect = writeCommit && hitPowerSelect;

  wire [`LM_LEVEL_WIDTH-1:0] levelWriteData = pwdata[`LM_LEVEL_WIDTH-1:0];
  wire [`LM_SELECT_WIDTH-1:0] selectWriteData = pwdata[`LM_SELECT_WIDTH-1:0];

  // High battery below low battery is not blocked here; ordering is software's duty [RULE5]
  ctrl_field_reg #(
    .WIDTH(`LM_LEVEL_WIDTH),
    .RESET_VALUE(`LM_RESET_COMMON_MODE)
  ) commonModeField (
    .clk(clk),
    .rst(rst),
    .writeEnable(writeCommonMode),
    .writeData(levelWriteData),
    .value(lineSettings.commonMode)
  ); // [RULE1] [RULE2]

  ctrl_field_reg #(
    .WIDTH(`LM_LEVEL_WIDTH),
    .RESET_VALUE(`LM_RESET_HIGH_BATTERY)
  ) highBatteryField (
    .clk(clk),
    .rst(rst),
    .writeEnable(writeHighBattery),
    .writeData(levelWriteData),
    .value(lineSettings.highBattery)
  ); // [RULE3]

  ctrl_field_reg #(
    .WIDTH(`LM_LEVEL_WIDTH),
    .RESET_VALUE(`LM_RESET_LOW_BATTERY)
  ) lowBatteryField (
    .clk(clk),
    .rst(rst),
    .writeEnable(writeLowBattery),
    .writeData(levelWriteData),
    .value(lineSettings.lowBattery)
  ); // [RULE4]

  ctrl_field_reg #(
    .WIDTH(`LM_SELECT_WIDTH),
    .RESET_VALUE(`LM_RESET_POWER_SELECT)
  ) powerSelectField (
    .clk(clk),
    .rst(rst),
    .writeEnable(writePowerSelect),
    .writeData(selectWriteData),
    .value(powerMonitorSelect)
  ); // [RULE6]

  power_monitor_mux #(
    .CHANNELS(CHANNELS)
  ) powerMux (
    .clk(clk),
    .rst(rst),
    .select(powerMonitorSelect),
    .transistorPower(transistorPower),
    .reading(powerReading),
    .lowRange(lowRangeSelected)
  ); // [RULE7] [RULE8] [RULE9]

  // Zero extension keeps every bit above a field at zero [RULE10]
  wire [`LM_DATA_WIDTH-1:0] readCommonMode = `LM_DATA_WIDTH'(lineSettings.commonMode);
  wire [`LM_DATA_WIDTH-1:0] readHighBattery = `LM_DATA_WIDTH'(lineSettings.highBattery);
  wire [`LM_DATA_WIDTH-1:0] readLowBattery = `LM_DATA_WIDTH'(lineSettings.lowBattery);
  wire [`LM_DATA_WIDTH-1:0] readPowerSelect = `LM_DATA_WIDTH'(powerMonitorSelect);
  wire [`LM_DATA_WIDTH-1:0] readPowerReading = `LM_DATA_WIDTH'(powerReading);

  // Read data is captured in the setup cycle from the registered reading, so the power is two cycles old at the answer
  wire [`LM_DATA_WIDTH-1:0] readSelected =
    hitCommonMode ? readCommonMode :
    hitHighBattery ? readHighBattery :
    hitLowBattery ? readLowBattery :
    hitPowerSelect ? readPowerSelect :
    hitPowerReading ? readPowerReading :
    `LM_IDLE_DATA; // [RULE10]

  always_comb begin
    apbState_next = apbState_reg;
    prdata_next = prdata;
    unique case (apbState_reg)
      APB_IDLE: begin
        prdata_next = `LM_IDLE_DATA;
        if (setupPhase) begin
          apbState_next = APB_ACCESS;
          prdata_next = (!pwrite && !accessBad) ? readSelected : `LM_IDLE_DATA;
        end
      end
      APB_ACCESS: begin
        if (accessDone || !psel) begin
          apbState_next = APB_IDLE;
          prdata_next = `LM_IDLE_DATA;
        end
      end
      default: begin
        apbState_next = APB_IDLE;
        prdata_next = `LM_IDLE_DATA;
      end
    endcase
  end

  // No wait state: pready rises in the first access cycle and stays for that cycle only
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      apbState_reg <= APB_IDLE;
      prdata <= `LM_IDLE_DATA;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      apbState_reg <= apbState_next;
      prdata <= prdata_next;
      pready <= setupPhase;
      pslverr <= setupPhase && accessBad;
    end
  end

endmodule

`default_nettype wire

// file: hdl/power_monitor_mux.sv
// Picks the power code of the selected transistor and holds it in a register
`timescale 1ns/10ps
`default_nettype none
`include "line_monitor_defines.svh"

module power_monitor_mux
  import line_monitor_pkg::*;
#(
  parameter int CHANNELS = 6
) (
  input wire logic clk,
  input wire logic rst,
  input wire select_code_t select,
  input wire logic [CHANNELS-1:0][`LM_READING_WIDTH-1:0] transistorPower,
  output reading_code_t reading,
  output logic lowRange
);

  if (CHANNELS < 1 || CHANNELS > (1 << `LM_SELECT_WIDTH)) begin : gen_channel_check
    $error("power_monitor_mux channel count out of range");
  end

  // Codes past the last transistor give no defined power; zero is reported
  wire selectValid = 32'(select) < CHANNELS;
  wire [`LM_READING_WIDTH-1:0] pickedPower = selectValid ? transistorPower[select] : `LM_RESET_READING;

  // Sampled every cycle so the reading tracks the live power code [RULE7]
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      reading <= `LM_RESET_READING;
      lowRange <= 1'b0;
    end else begin
      reading <= pickedPower; // [RULE6]
      lowRange <= selectValid && isLowRangeCode(select); // [RULE8] [RULE9]
    end
  end

endmodule

`default_nettype wire

// file: verif/line_monitor_properties.sv
// Port checks for the line monitor register bank
`timescale 1ns/10ps
`default_nettype none
`include "line_monitor_defines.svh"
module line_monitor_checker
  import line_monitor_pkg::*;
#(
  parameter int ADDR_WIDTH = 12,
  parameter int CHANNELS = 6
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_WIDTH-1:0] paddr,
  input wire logic [`LM_DATA_WIDTH-1:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [`LM_DATA_WIDTH-1:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [CHANNELS-1:0][`LM_READING_WIDTH-1:0] transistorPower,
  input wire line_settings_t lineSettings,
  input wire select_code_t powerMonitorSelect,
  input wire logic lowRangeSelected
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  wire wrDone = psel && penable && pready && pwrite && pstrb[0] && !pslverr;
  chk_common_store: assert property (wrDone && paddr == 'h124
    |=> lineSettings.commonMode == $past(pwdata[5:0])) else $error("common mode lost");
  chk_high_store: assert property (wrDone && paddr == 'h128
    |=> lineSettings.highBattery == $past(pwdata[5:0])) else $error("high battery lost");
  chk_low_store: assert property (wrDone && paddr == 'h12C
    |=> lineSettings.lowBattery == $past(pwdata[5:0])) else $error("low battery lost");
  chk_pointer_store: assert property (wrDone && paddr == 'h130
    |=> powerMonitorSelect == $past(pwdata[2:0])) else $error("pointer lost");
  chk_reset_values: assert property ($fell(rst) |-> powerMonitorSelect == '0 &&
    lineSettings == {6'h02, 6'h32, 6'h10}) else $error("bad reset level");
  chk_upper_zero: assert property (pready && !pwrite && !pslverr |->
    prdata[31:8] == '0 && (paddr > 'h12C || prdata[7:6] == '0)) else $error("upper bits set");
  chk_reading_ro: assert property (pready && pwrite && paddr == 'h134
    |-> pslverr) else $error("reading accepted a write");
  chk_fine_scale: assert property (lowRangeSelected ==
    ($past(powerMonitorSelect) inside {3'h2, 3'h3})) else $error("scale flag wrong");
endmodule
bind line_voltage_power_monitor_regs line_monitor_checker #(
  .ADDR_WIDTH(ADDR_WIDTH), .CHANNELS(CHANNELS)) line_monitor_checker_inst (
  .clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .transistorPower(transistorPower), .lineSettings(lineSettings),
  .powerMonitorSelect(powerMonitorSelect), .lowRangeSelected(lowRangeSelected));
`default_nettype wire

// file: verif/tb.sv
// Self-checking bench for the line monitor register bank
`timescale 1ns/10ps
`default_nettype none
`include "line_monitor_defines.svh"
module tb;
  import line_monitor_pkg::*;
  logic clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, pready, pslverr, lowRange, rdErr;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rdData, d;
  logic [3:0] pstrb = '0, s;
  logic [5:0][7:0] transistorPower = '0;
  line_settings_t lineSettings;
  select_code_t powerMonitorSelect;
  logic [5:0] m [4];
  int bad_count = 0, checked = 0, cycles = 0, i, k;
  line_voltage_power_monitor_regs line_voltage_power_monitor_regs_inst (
    .clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .transistorPower(transistorPower), .lineSettings(lineSettings),
    .powerMonitorSelect(powerMonitorSelect), .lowRangeSelected(lowRange));
  initial forever #12.5 clk = ~clk;
  task automatic end_of_test();
    $display("checked %0d bad_count %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // The run needs under a thousand cycles
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      bad_count++;
      end_of_test();
    end
  end
  task automatic cmp(input string n, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      $display("wrong value %s expected %h seen %h", n, e, g);
      bad_count++;
    end
  endtask
  // Index r counts registers from the common mode level, four bytes apart
  task automatic apb(input logic w, input int r, input logic [31:0] dat, input logic [3:0] st);
    @(posedge clk);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= 12'((`LM_IDX_COMMON_MODE + r) * 4);
    pwdata <= dat;
    pstrb <= st;
    @(posedge clk);
    penable <= 1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rdData = prdata;
    rdErr = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  function automatic logic [5:0] field(input int r, input logic [31:0] v);
    field = (r == 3) ? {3'h0, v[2:0]} : v[5:0];
  endfunction
  initial begin
    void'($urandom(32'hDC49));
    repeat (10) @(posedge clk);
    rst <= 0;
    m = '{6'h02, 6'h32, 6'h10, 6'h00};
    for (i = 0; i < 4; i++) begin
      apb(0, i, 0, 0);
      cmp("reset value", 32'(m[i]), rdData);
    end
    for (k = 0; k < 60; k++) begin
      i = $urandom % 4;
      d = (k < 4) ? 32'hFFFFFFFF : (k < 8) ? 32'h0 : $urandom;
      if (i == 1 && d[5:0] < m[2]) d[5:0] = m[2];
      if (i == 2 && d[5:0] > m[1]) d[5:0] = m[1];
      s = (k < 8) ? 4'h1 : 4'($urandom);
      apb(1, i, d, s);
      if (s[0]) m[i] = field(i, d);
      apb(0, i, 0, 0);
      cmp("readback", 32'(m[i]), rdData);
      cmp("settings", 32'({m[0], m[1], m[2]}), 32'(lineSettings));
    end
    for (k = 0; k < 8; k++) begin
      transistorPower <= (k == 0) ? '1 : 48'({$urandom, $urandom});
      apb(1, 3, k, 4'h1);
      apb(0, 4, 0, 0);
      cmp("power", (k < 6) ? 32'(transistorPower[k]) : 32'h0, rdData);
      cmp("fine scale", 32'(k == 2 || k == 3), 32'(lowRange));
      cmp("pointer", 32'(k), 32'(powerMonitorSelect));
    end
    apb(1, 4, 32'hFF, 4'hF);
    cmp("reading write error", 32'h1, 32'(rdErr));
    apb(0, 32'h37, 0, 0);
    cmp("unmapped error", 32'h1, 32'(rdErr));
    rst <= 1;
    repeat (2) @(posedge clk);
    rst <= 0;
    apb(0, 0, 0, 0);
    cmp("common mode after reset", 32'h2, rdData);
    cmp("reset levels", 32'({6'h02, 6'h32, 6'h10}), 32'(lineSettings));
    cmp("pointer after reset", 32'h0, 32'(powerMonitorSelect));
    cmp("scale after reset", 32'h0, 32'(lowRange));
    end_of_test();
  end
endmodule
`default_nettype wire
